//--- core/pwt_timer.sv
// PWM timer with dead time, capture mode and AXI4-Lite registers
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module pwt_timer import pwt_pkg::*; #(
    parameter logic [7:0] INIT_PORT_DATA = 8'h00,
    parameter logic [7:0] INIT_PORT_CFG = 8'h21
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic sys_reset_i,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic comparator_kill_i,
    input wire logic high_side_b_in_i,
    output logic high_side_out_a_o,
    output logic high_side_a_oe_n_o,
    output logic high_side_out_b_o,
    output logic high_side_b_oe_n_o,
    output logic conversion_strobe_o,
    output logic strobe_oe_n_o,
    output logic adc_start_o,
    output logic timer_irq_o
);
    // =========================================================
    // Registers
    logic [7:0] ctrl_r;
    logic [CNT_W-1:0] period_capture_reg;
    logic [CNT_W-1:0] compare_a_reg;
    logic [CNT_W-1:0] compare_b_reg;
    logic [DT_W-1:0] dead_time_reg;
    logic [PS_W-1:0] prescale_reg;
    logic [7:0] port_data_reg;
    logic [7:0] port_config_reg;
    logic [2:0] misc_r;
    logic [CNT_W-1:0] pwm_counter;
    logic [DT_W-1:0] dt_cnt_r;
    pwt_state_t state_r;
    logic hs_a_r;
    logic hs_b_r;
    logic strobe_r;
    logic tick;
    logic cap_rise;
    logic cap_fall;

    logic [2:0] mode;
    logic capture_mode;
    logic run_overflow_bit;
    logic period_pending_flag;
    assign mode = ctrl_r[CTRL_MODE_HI:CTRL_MODE_LO];
    assign capture_mode = mode[MODE_CAPTURE];
    assign run_overflow_bit = ctrl_r[CTRL_RUN];
    assign period_pending_flag = ctrl_r[CTRL_PEND];

    function automatic logic [31:0] zext8(input logic [7:0] v);
        zext8 = {24'h000000, v};
    endfunction
    function automatic logic [31:0] zext12(input logic [CNT_W-1:0] v);
        zext12 = {20'h00000, v};
    endfunction

    // =========================================================
    // Timer tick and capture synchroniser
    pwt_prescaler #(.W(PS_W)) pwt_prescaler_i (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .div_i(prescale_reg),
        .tick_o(tick)
    );

    pwt_sync pwt_sync_i (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .en_i(ce_i & tick),
        .d_i(high_side_b_in_i),
        .rise_o(cap_rise),
        .fall_o(cap_fall)
    );

    logic cap_evt;
    logic kill;
    logic period_hit;
    logic wrap_cap;
    logic cycle_done;
    logic hw_set_pend;
    logic hw_set_ovf;
    logic dt_zero;
    assign cap_evt = capture_mode & (mode[MODE_EDGE] ? cap_fall : cap_rise);
    assign kill = misc_r[MISC_KILL_EN] & comparator_kill_i;
    assign period_hit = tick && state_r == PWT_COUNT && !capture_mode
        && pwm_counter == period_capture_reg;
    assign wrap_cap = tick && state_r == PWT_COUNT && capture_mode
        && pwm_counter == CNT_MAX;
    assign dt_zero = (dt_cnt_r == '0);
    // Cycle completes only after the dead time after the period match
    assign cycle_done = state_r == PWT_DEAD && dt_zero;
    assign hw_set_pend = period_hit | cap_evt;
    assign hw_set_ovf = wrap_cap;

    // =========================================================
    // AXI4-Lite slave
    logic aw_hold_r;
    logic w_hold_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic wr_fire;
    assign wr_fire = aw_hold_r && w_hold_r && !s_axi_bvalid;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (ce_i) begin
            s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_r <= ADDR_MISC && awaddr_r[1:0] == 2'b00)
                    ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register writes; only the low byte lane carries the 8-bit controls
    logic wr_lo;
    logic wr_hi;
    assign wr_lo = wr_fire && wstrb_r[0];
    assign wr_hi = wr_fire && wstrb_r[1];

    logic stop_req;
    assign stop_req = kill && misc_r[MISC_KILL_ALL];

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_r <= '0;
        end else if (ce_i) begin
            if (sys_reset_i) begin
                ctrl_r <= '0;
            end else begin
                if (wr_lo && awaddr_r == ADDR_CTRL) begin
                    ctrl_r[CTRL_MODE_HI:CTRL_MODE_LO] <= wdata_r[CTRL_MODE_HI:CTRL_MODE_LO];
                    ctrl_r[CTRL_IRQ_EN] <= wdata_r[CTRL_IRQ_EN];
                    ctrl_r[CTRL_STROBE_EN] <= wdata_r[CTRL_STROBE_EN];
                    // Pending bits are write-zero-to-clear; a hardware set wins
                    ctrl_r[CTRL_PEND] <= ctrl_r[CTRL_PEND] & wdata_r[CTRL_PEND];
                    if (wdata_r[CTRL_MODE_HI] || ctrl_r[CTRL_MODE_HI])
                        ctrl_r[CTRL_RUN] <= ctrl_r[CTRL_RUN] & wdata_r[CTRL_RUN];
                    else
                        ctrl_r[CTRL_RUN] <= wdata_r[CTRL_RUN];
                end
                if (hw_set_pend)
                    ctrl_r[CTRL_PEND] <= 1'b1;
                if (hw_set_ovf)
                    ctrl_r[CTRL_RUN] <= 1'b1;
                if (stop_req && !capture_mode)
                    ctrl_r[CTRL_RUN] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            period_capture_reg <= '0;
            compare_a_reg <= '0;
            compare_b_reg <= '0;
            dead_time_reg <= '0;
            prescale_reg <= '0;
            misc_r <= '0;
        end else if (ce_i) begin
            if (cap_evt)
                period_capture_reg <= pwm_counter;
            else if (wr_lo && wr_hi && awaddr_r == ADDR_PERIOD)
                period_capture_reg <= wdata_r[CNT_W-1:0];
            if (wr_lo && wr_hi && awaddr_r == ADDR_CMPA)
                compare_a_reg <= wdata_r[CNT_W-1:0];
            if (wr_lo && wr_hi && awaddr_r == ADDR_CMPB)
                compare_b_reg <= wdata_r[CNT_W-1:0];
            if (wr_lo && awaddr_r == ADDR_DEAD_TIME_REG)
                dead_time_reg <= wdata_r[DT_W-1:0];
            if (wr_lo && awaddr_r == ADDR_PRESCALE_REG)
                prescale_reg <= wdata_r[PS_W-1:0];
            if (wr_lo && awaddr_r == ADDR_MISC)
                misc_r <= wdata_r[2:0];
        end
    end

    // Port registers: reset clears them; system reset drives the bridge pins, strobe pin input
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_data_reg <= PORT_RST;
            port_config_reg <= PORT_RST;
        end else if (ce_i) begin
            if (sys_reset_i) begin
                port_data_reg <= INIT_PORT_DATA;
                port_config_reg <= INIT_PORT_CFG;
            end else begin
                if (wr_lo && awaddr_r == ADDR_PORTD)
                    port_data_reg <= wdata_r[7:0];
                if (wr_lo && awaddr_r == ADDR_PORTC)
                    port_config_reg <= wdata_r[7:0];
            end
        end
    end

    // Read channel
    logic [31:0] rd_mux;
    always_comb begin
        case (s_axi_araddr)
            ADDR_CTRL: rd_mux = zext8(ctrl_r);
            ADDR_PERIOD: rd_mux = zext12(period_capture_reg);
            ADDR_CMPA: rd_mux = zext12(compare_a_reg);
            ADDR_CMPB: rd_mux = zext12(compare_b_reg);
            ADDR_DEAD_TIME_REG: rd_mux = zext8({3'b000, dead_time_reg});
            ADDR_PRESCALE_REG: rd_mux = zext8(prescale_reg);
            ADDR_PORTD: rd_mux = zext8(port_data_reg);
            ADDR_PORTC: rd_mux = zext8(port_config_reg);
            ADDR_MISC: rd_mux = zext8({5'b00000, misc_r});
            ADDR_COUNT: rd_mux = zext12(pwm_counter);
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (ce_i) begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= (s_axi_araddr <= ADDR_COUNT && s_axi_araddr[1:0] == 2'b00)
                    ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // =========================================================
    // Counter and dead-time sequencer
    // Dead time runs on the system clock so the prescaler cannot stretch it
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= PWT_IDLE;
            pwm_counter <= CNT_ZERO;
            dt_cnt_r <= '0;
        end else if (ce_i) begin
            if (sys_reset_i || stop_req) begin
                state_r <= PWT_IDLE;
                pwm_counter <= CNT_ZERO;
                dt_cnt_r <= '0;
            end else begin
                case (state_r)
                    PWT_IDLE: begin
                        pwm_counter <= CNT_ZERO;
                        if (capture_mode || run_overflow_bit)
                            state_r <= PWT_COUNT;
                    end
                    PWT_COUNT: begin
                        if (period_hit) begin
                            pwm_counter <= CNT_ZERO;
                            dt_cnt_r <= dead_time_reg;
                            state_r <= PWT_DEAD;
                        end else if (tick) begin
                            pwm_counter <= pwm_counter + 1'b1;
                        end
                    end
                    PWT_DEAD: begin
                        if (dt_zero)
                            state_r <= (run_overflow_bit && !kill) ? PWT_COUNT : PWT_IDLE;
                        else
                            dt_cnt_r <= dt_cnt_r - 1'b1;
                    end
                    default: state_r <= PWT_IDLE;
                endcase
                if (state_r == PWT_COUNT && hs_a_r && !hs_b_r && !period_hit) begin
                    if (dt_cnt_r != '0)
                        dt_cnt_r <= dt_cnt_r - 1'b1;
                end
                if (state_r == PWT_COUNT && !capture_mode && !period_hit && tick
                    && pwm_counter == compare_a_reg)
                    dt_cnt_r <= dead_time_reg;
                if (state_r == PWT_COUNT && !capture_mode && !run_overflow_bit
                    && pwm_counter > period_capture_reg)
                    state_r <= PWT_IDLE;
            end
        end
    end

    // =========================================================
    // Internal phases of A, B and strobe
    logic match_a;
    logic match_b;
    assign match_a = tick && state_r == PWT_COUNT && pwm_counter == compare_a_reg;
    assign match_b = tick && state_r == PWT_COUNT && pwm_counter == compare_b_reg;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hs_a_r <= 1'b0;
            hs_b_r <= 1'b0;
            strobe_r <= 1'b0;
            adc_start_o <= 1'b0;
        end else if (ce_i) begin
            adc_start_o <= 1'b0;
            if (sys_reset_i || kill || state_r == PWT_IDLE) begin
                hs_a_r <= 1'b0;
                hs_b_r <= 1'b0;
                strobe_r <= 1'b0;
            end else begin
                if (match_a && !period_hit)
                    hs_a_r <= 1'b1;
                if (!capture_mode && hs_a_r && !hs_b_r && state_r == PWT_COUNT && dt_zero)
                    hs_b_r <= 1'b1;
                if (match_b && !period_hit) begin
                    strobe_r <= 1'b1;
                    adc_start_o <= !strobe_r && misc_r[MISC_AUTO_SAMPLE];
                end
                if (period_hit || wrap_cap) begin
                    hs_b_r <= 1'b0;
                    strobe_r <= 1'b0;
                    if (capture_mode)
                        hs_a_r <= 1'b0;
                end
                if (cycle_done)
                    hs_a_r <= 1'b0;
            end
        end
    end

    // =========================================================
    // Pins: toggle select, polarity and drive enables
    logic tog_a;
    logic tog_b;
    assign tog_a = mode[MODE_TOG_A];
    assign tog_b = !capture_mode && mode[MODE_TOG_B];

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            high_side_out_a_o <= 1'b0;
            high_side_out_b_o <= 1'b0;
            conversion_strobe_o <= 1'b0;
            high_side_a_oe_n_o <= 1'b1;
            high_side_b_oe_n_o <= 1'b1;
            strobe_oe_n_o <= 1'b1;
            timer_irq_o <= 1'b0;
        end else if (ce_i) begin
            high_side_out_a_o <= (tog_a & hs_a_r) ^ port_data_reg[PORT_POL_A];
            high_side_out_b_o <= (tog_b & hs_b_r) ^ port_data_reg[PORT_POL_B];
            conversion_strobe_o <= strobe_r ^ port_data_reg[PORT_POL_S];
            high_side_a_oe_n_o <= !port_config_reg[PORT_POL_A];
            high_side_b_oe_n_o <= capture_mode || !port_config_reg[PORT_POL_B];
            strobe_oe_n_o <= !(ctrl_r[CTRL_STROBE_EN] && port_config_reg[PORT_POL_S]);
            timer_irq_o <= ctrl_r[CTRL_IRQ_EN] && (period_pending_flag
                || (capture_mode && run_overflow_bit));
        end
    end
endmodule // pwt_timer
`default_nettype wire

//--- pkg/pwt_pkg.sv
// Package for the PWM timer with dead time and input capture
package pwt_pkg;
    // =========================================================
    // Widths and register map (byte addresses on AXI4-Lite)
    localparam int CNT_W = 12;
    localparam int DT_W = 5;
    localparam int PS_W = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PERIOD = 8'h04;
    localparam logic [7:0] ADDR_CMPA = 8'h08;
    localparam logic [7:0] ADDR_CMPB = 8'h0c;
    localparam logic [7:0] ADDR_DEAD_TIME_REG = 8'h10;
    localparam logic [7:0] ADDR_PRESCALE_REG = 8'h14;
    localparam logic [7:0] ADDR_PORTD = 8'h18;
    localparam logic [7:0] ADDR_PORTC = 8'h1c;
    localparam logic [7:0] ADDR_MISC = 8'h20;
    localparam logic [7:0] ADDR_COUNT = 8'h24;
    // =========================================================
    // Register fields, mode bits and constants
    localparam int CTRL_STROBE_EN = 0;
    localparam int CTRL_IRQ_EN = 2;
    localparam int CTRL_PEND = 3;
    localparam int CTRL_RUN = 4;
    localparam int CTRL_MODE_LO = 5;
    localparam int CTRL_MODE_HI = 7;
    localparam int PORT_POL_A = 0;
    localparam int PORT_POL_S = 1;
    localparam int PORT_POL_B = 5;
    localparam int MISC_AUTO_SAMPLE = 0;
    localparam int MISC_KILL_EN = 1;
    localparam int MISC_KILL_ALL = 2;
    localparam int MODE_CAPTURE = 2;
    localparam int MODE_EDGE = 1;
    localparam int MODE_TOG_A = 0;
    localparam int MODE_TOG_B = 1;
    localparam logic [7:0] PORT_RST = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
    localparam logic [CNT_W-1:0] CNT_MAX = 12'hfff;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        PWT_IDLE = 3'b001,
        PWT_COUNT = 3'b010,
        PWT_DEAD = 3'b100
    } pwt_state_t;
endpackage

//--- core/pwt_prescaler.sv
// Prescaler that makes the timer clock enable
`timescale 1ns/1ps
`default_nettype none
module pwt_prescaler import pwt_pkg::*; #(
    parameter int W = PS_W
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [W-1:0] div_i,
    output logic tick_o
);
    logic [W-1:0] cnt_r;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= '0;
            tick_o <= 1'b0;
        end else if (ce_i) begin
            // Divide by div_i+1
            if (cnt_r >= div_i) begin
                cnt_r <= '0;
                tick_o <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 1'b1;
                tick_o <= 1'b0;
            end
        end
    end
endmodule // pwt_prescaler
`default_nettype wire

//--- core/pwt_sync.sv
// Two-stage synchroniser with edge detection on the timer clock
`timescale 1ns/1ps
`default_nettype none
module pwt_sync (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic d_i,
    output logic rise_o,
    output logic fall_o
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else if (en_i) begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    assign rise_o = en_i & s2_r & ~s3_r;
    assign fall_o = en_i & ~s2_r & s3_r;
endmodule // pwt_sync
`default_nettype wire

//--- bench/pwt_timer_sva.sv
// Port checker for the PWM timer
`timescale 1ns/1ps
`default_nettype none
module pwt_timer_sva (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic sys_reset_i,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic high_side_out_a_o,
    input wire logic high_side_out_b_o,
    input wire logic adc_start_o,
    input wire logic timer_irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ==========================================================
    // Bus and pin relations
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("rvalid dropped early");
    aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready longer than one cycle");
    read_answer_a: assert property (s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    adc_pulse_a: assert property (adc_start_o |=> !adc_start_o)
        else $error("conversion start not a pulse");
    boot_rest_a: assert property (
        $rose(rst_n_i) |-> !(high_side_out_a_o | high_side_out_b_o | timer_irq_o))
        else $error("pins active after reset");
    sys_rest_a: assert property (
        (sys_reset_i && ce_i)[*3] |-> !(high_side_out_a_o | high_side_out_b_o | timer_irq_o))
        else $error("pins active in system reset");
    dead_order_a: assert property ($rose(high_side_out_b_o) |-> !$rose(high_side_out_a_o))
        else $error("bridge outputs rose together");
    cover property ($rose(high_side_out_b_o));
    cover property (adc_start_o);
    cover property ($rose(timer_irq_o));
endmodule // pwt_timer_sva
`default_nettype wire

//--- bench/pwt_cap_model.sv
// Capture signal source standing in for the external input stage
`timescale 1ns/1ps
`default_nettype none
module pwt_cap_model (
    input wire logic clk_i,
    input wire logic toggle_i,
    output logic cap_o
);
    initial cap_o = 1'b0;
    // Changes just after an edge, so the design sees a clean asynchronous step
    always @(posedge clk_i) begin
        if (toggle_i) begin
            cap_o <= ~cap_o;
        end
    end
endmodule // pwt_cap_model
`default_nettype wire

//--- bench/test_pwm_timer_dead_time_capture.sv
// Testbench for the PWM timer through its register bus and pins
`timescale 1ns/1ps
`default_nettype none
module test_pwm_timer_dead_time_capture import pwt_pkg::*;;
    logic clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, sys_reset_i = 1'b0, tog = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d, prev;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, comparator_kill_i = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
    logic high_side_b_in_i, high_side_out_a_o, high_side_a_oe_n_o, high_side_out_b_o;
    logic high_side_b_oe_n_o, conversion_strobe_o, strobe_oe_n_o, adc_start_o, timer_irq_o;
    int num_errors = 0, num_checks = 0, adc_n = 0, g[3], p[3], i, n;
    always #2.5 clk_i = ~clk_i;
    pwt_timer pwt_timer_i (.clk_i, .rst_n_i, .ce_i, .sys_reset_i, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .comparator_kill_i, .high_side_b_in_i, .high_side_out_a_o,
        .high_side_a_oe_n_o, .high_side_out_b_o, .high_side_b_oe_n_o,
        .conversion_strobe_o, .strobe_oe_n_o, .adc_start_o, .timer_irq_o);
    pwt_cap_model pwt_cap_model_i (.clk_i, .toggle_i(tog), .cap_o(high_side_b_in_i));
    // ==========================================================
    // Tasks
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
        num_checks++;
        if (v !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", s, e, v);
        end
    endtask
    task automatic step(inout int k);
        @(posedge clk_i);
        k++;
        adc_n += (adc_start_o === 1'b1);
        if (k > 8000) begin
            chk("wait bound", 32'h0, k);
            summarize();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (s_axi_bvalid !== 1'b1) begin
            step(k);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end
        chk("write resp", RESP_OKAY, s_axi_bresp);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        int k;
        k = 0;
        @(posedge clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (s_axi_rvalid !== 1'b1) begin
            step(k);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end
        rd_d = s_axi_rdata;
        rd_r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // One whole cycle is skipped so settings written mid-cycle have landed
    task automatic gaps(output int gd, output int gp);
        int k;
        k = 0;
        while (high_side_out_a_o !== 1'b1) step(k);
        while (high_side_out_a_o !== 1'b0) step(k);
        while (high_side_out_a_o !== 1'b1) step(k);
        k = 0;
        while (high_side_out_b_o !== 1'b1) step(k);
        gd = k;
        while (high_side_out_a_o !== 1'b0) step(k);
        while (high_side_out_a_o !== 1'b1) step(k);
        gp = k;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(ADDR_CTRL);
        chk("ctrl reset", 32'h0, rd_d);
        chk("pins idle", 32'h0, {high_side_out_a_o, high_side_out_b_o, conversion_strobe_o});
        rd(8'h28);
        chk("unmapped resp", RESP_SLVERR, rd_r);
        $display("test reset done");
        wr(ADDR_PORTC, 32'h23);
        wr(ADDR_PERIOD, 32'h14);
        wr(ADDR_CMPA, 32'h5);
        wr(ADDR_CMPB, 32'h8);
        wr(ADDR_MISC, 32'h1);
        for (i = 0; i < 3; i++) begin
            wr(ADDR_DEAD_TIME_REG, (i == 1) ? 32'h6 : 32'h3);
            wr(ADDR_PRESCALE_REG, (i == 2) ? 32'h1 : 32'h0);
            wr(ADDR_CTRL, 32'h75);
            gaps(g[i], p[i]);
        end
        chk("dead time step", 32'h3, g[1] - g[0]);
        chk("dead time prescaled", g[0], g[2]);
        chk("period plus dead", 32'h3, p[1] - p[0]);
        chk("adc start", 32'h1, adc_n > 0);
        chk("irq", 32'h1, timer_irq_o);
        chk("strobe pin on", 32'h0, strobe_oe_n_o);
        chk("bridge pins on", 32'h0, {high_side_a_oe_n_o, high_side_b_oe_n_o});
        wr(ADDR_CTRL, 32'h65);
        prev = 32'h1;
        rd_d = 32'h1;
        n = 0;
        while (rd_d !== 32'h0 || prev !== 32'h0) begin
            prev = rd_d;
            rd(ADDR_COUNT);
            step(n);
        end
        wr(ADDR_CTRL, 32'h6d);
        rd(ADDR_CTRL);
        chk("pending kept", 32'h1, rd_d[CTRL_PEND]);
        wr(ADDR_CTRL, 32'h65);
        rd(ADDR_CTRL);
        chk("pending cleared", 32'h0, rd_d[CTRL_PEND]);
        chk("irq cleared", 32'h0, timer_irq_o);
        wr(ADDR_PORTD, 32'h1);
        rd(ADDR_PORTD);
        chk("a polarity", 32'h2, {high_side_out_a_o, high_side_out_b_o});
        wr(ADDR_PORTD, 32'h23);
        rd(ADDR_PORTD);
        chk("b and strobe polarity", 32'h7, {high_side_out_a_o, high_side_out_b_o,
            conversion_strobe_o});
        wr(ADDR_PORTD, 32'h0);
        wr(ADDR_MISC, 32'h3);
        comparator_kill_i <= 1'b1;
        wr(ADDR_CTRL, 32'h75);
        for (i = 0, n = 0; n < 200; i += (high_side_out_a_o === 1'b1)) step(n);
        chk("kill holds off", 32'h0, i);
        comparator_kill_i <= 1'b0;
        $display("test pwm done");
        wr(ADDR_PRESCALE_REG, 32'h0);
        // Second write clears a flag set while the mode changed
        wr(ADDR_CTRL, 32'h84);
        wr(ADDR_CTRL, 32'h84);
        tog <= 1'b1;
        @(posedge clk_i);
        tog <= 1'b0;
        for (n = 0; timer_irq_o !== 1'b1; ) step(n);
        chk("capture delay", 32'h1, n <= 6);
        chk("capture pin input", 32'h1, high_side_b_oe_n_o);
        rd(ADDR_CTRL);
        chk("capture pending", 32'h1, rd_d[CTRL_RUN:CTRL_PEND]);
        wr(ADDR_CTRL, 32'h94);
        rd(ADDR_CTRL);
        chk("capture irq cleared", 32'h0, timer_irq_o);
        for (n = 0; timer_irq_o !== 1'b1; ) step(n);
        rd(ADDR_CTRL);
        chk("overflow pending", 32'h2, rd_d[CTRL_RUN:CTRL_PEND]);
        sys_reset_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        sys_reset_i <= 1'b0;
        rd(ADDR_CTRL);
        chk("system reset", 32'h0, rd_d);
        $display("test capture done");
        summarize();
    end
endmodule // test_pwm_timer_dead_time_capture
bind pwt_timer pwt_timer_sva pwt_timer_sva_i (.clk_i, .rst_n_i, .ce_i, .sys_reset_i,
    .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .high_side_out_a_o, .high_side_out_b_o, .adc_start_o, .timer_irq_o);
`default_nettype wire
